// ---- verilog/pllm_pkg.sv ----
//----------------------------------------------------------------------
// Purpose : constants and types for the pll lock event monitor
// Assumes : one core clock, synchronous active-high reset
// Notes   : register indices are held here, data is 8 bits wide
//----------------------------------------------------------------------
package pllm_pkg;

	//------------------------------------------------------------------
	// register map
	//------------------------------------------------------------------
	localparam int          ADDR_W           = 2;
	localparam int          DATA_W           = 8;
	localparam logic [1:0]  PLL_LOCK_STATUS_IDX       = 2'h0;
	localparam logic [1:0]  PLL_EVENT_FLAGS_IDX       = 2'h1;
	localparam logic [1:0]  PLL_LOCK_LOSS_COUNTER_IDX = 2'h2;
	localparam logic [7:0]  REG_RESET_VAL    = 8'h00;

	//------------------------------------------------------------------
	// field positions
	//------------------------------------------------------------------
	localparam int          STS_LOCK_BIT     = 0;
	localparam int          STS_RAIL_LOW_BIT = 1;
	localparam int          STS_RAIL_HIGH_BIT = 2;
	localparam int          EVT_LOL_BIT      = 0;
	localparam int          EVT_RAIL_LOW_BIT = 1;
	localparam int          EVT_RAIL_HIGH_BIT = 2;
	localparam int          EVT_W            = 3;
	localparam int          CNT_W            = 4;
	localparam logic [3:0]  CNT_ZERO         = 4'h0;
	localparam logic [3:0]  CNT_MAX          = 4'hf;
	localparam logic [3:0]  CNT_ONE          = 4'h1;

	//------------------------------------------------------------------
	// debounce intervals in system clock cycles
	//------------------------------------------------------------------
	localparam int          DEB_W            = 16;
	localparam int          DEB_SHORT_CYC    = 570;
	localparam int          DEB_MID_CYC      = 5700;
	localparam int          DEB_LONG_CYC     = 57000;
	localparam logic [1:0]  DEB_SEL_NONE     = 2'h0;
	localparam logic [1:0]  DEB_SEL_SHORT    = 2'h1;
	localparam logic [1:0]  DEB_SEL_MID      = 2'h2;
	localparam logic [1:0]  DEB_SEL_LONG     = 2'h3;
	localparam logic [15:0] DEB_ZERO         = 16'h0000;
	localparam logic [15:0] DEB_ONE          = 16'h0001;

	//------------------------------------------------------------------
	// carriers
	//------------------------------------------------------------------
	typedef struct packed {
		logic [1:0] addr;
		logic       wr;
		logic [7:0] wdata;
	} pllm_reg_req_t;

	typedef struct packed {
		logic raw_lock;
		logic rail_high;
		logic rail_low;
	} pllm_det_t;

endpackage

// ---- verilog/pllm_monitor.sv ----
//----------------------------------------------------------------------
// Purpose : lock status, sticky events and loss-of-lock counter
// Assumes : detector inputs synchronous to i_core_clk (25 MHz)
// Notes   : read data is registered, one cycle after the address
//----------------------------------------------------------------------
// Functional notes
// RULE_01 - status bit 0 shows the live debounced lock indication
// RULE_02 - status bit 2 shows the live rail-high indication
// RULE_03 - status bit 1 shows the live rail-low indication
// RULE_04 - event bit 2 sets on rail-high and holds until cleared
// RULE_05 - event bit 1 sets on rail-low and holds until cleared
// RULE_06 - event bit 0 sets when lock falls and holds until cleared
// RULE_07 - an event flag clears only when software writes 1 to it
// RULE_08 - 4-bit counter counts each lock loss and saturates at 0xf
// RULE_09 - writing the counter loads the written value, 0 clears it
// RULE_10 - lock debounced by 0, 570, 5700 or 57000 cycles, 2-bit select
// RULE_11 - sticky lock mode keeps lock asserted once it first asserts
// RULE_12 - writing 0 leaves a flag alone; a hardware set beats a clear
// RULE_13 - registers reset to zero, reserved bits read zero
`timescale 1ns/100ps

module pllm_monitor
	import pllm_pkg::*;
#(
	parameter int DEB_MID_CYCLES  = DEB_MID_CYC,
	parameter int DEB_LONG_CYCLES = DEB_LONG_CYC
) (
	// clock, reset, enable
	input  wire logic          i_core_clk,
	input  wire logic          i_sys_rst,
	input  wire logic          i_clk_en,
	// lock detector indications
	input  wire pllm_det_t     i_det,
	// configuration
	input  wire logic [1:0]    i_lock_timer_sel,
	input  wire logic          i_sticky_lock_select,
	// register port
	input  wire pllm_reg_req_t i_reg_req,
	output logic [7:0]         o_reg_rdata,
	// debounced lock indication
	output logic               o_lock
);

	//------------------------------------------------------------------
	// helpers
	//------------------------------------------------------------------
	function automatic logic [3:0] sat_inc(input logic [3:0] v);
		sat_inc = (v == CNT_MAX) ? CNT_MAX : 4'(v + CNT_ONE);
	endfunction

	function automatic logic [15:0] deb_limit(input logic [1:0] sel);
		unique case (sel)
			DEB_SEL_NONE:  deb_limit = DEB_ZERO;
			DEB_SEL_SHORT: deb_limit = 16'(DEB_SHORT_CYC);
			DEB_SEL_MID:   deb_limit = 16'(DEB_MID_CYCLES);
			DEB_SEL_LONG:  deb_limit = 16'(DEB_LONG_CYCLES);
		endcase
	endfunction

	//------------------------------------------------------------------
	// state
	//------------------------------------------------------------------
	logic [15:0]      deb_cnt_reg;
	logic [15:0]      deb_cnt_next;
	logic             deb_reg;
	logic             deb_next;
	logic             lock_reg;
	logic             lock_next;
	logic [EVT_W-1:0] evt_reg;
	logic [EVT_W-1:0] evt_next;
	logic [3:0]       cnt_reg;
	logic [3:0]       cnt_next;
	logic [7:0]       rdata_next;

	//------------------------------------------------------------------
	// decode
	//------------------------------------------------------------------
	wire              wr_evt;
	wire              wr_cnt;
	wire [15:0]       limit;
	wire              differs;
	wire              settled;
	wire              lock_fall;
	wire [EVT_W-1:0]  evt_set;
	wire [EVT_W-1:0]  evt_clr;
	wire [3:0]        cnt_base;
	wire [7:0]        sts_word;

	assign wr_evt  = i_reg_req.wr && (i_reg_req.addr == PLL_EVENT_FLAGS_IDX);
	assign wr_cnt  = i_reg_req.wr &&
	                 (i_reg_req.addr == PLL_LOCK_LOSS_COUNTER_IDX);

	//------------------------------------------------------------------
	// debounce and sticky lock
	//------------------------------------------------------------------
	assign limit   = deb_limit(i_lock_timer_sel);
	assign differs = i_det.raw_lock != deb_reg;
	// raw level must hold for the whole interval before it is taken
	assign settled = (limit == DEB_ZERO) ||
	                 (deb_cnt_reg >= 16'(limit - DEB_ONE));           // [RULE_10]

	assign deb_next     = (differs && settled) ? i_det.raw_lock : deb_reg;
	assign deb_cnt_next = (!differs || settled) ? DEB_ZERO :
	                      16'(deb_cnt_reg + DEB_ONE);
	assign lock_next    = deb_next ||
	                      (i_sticky_lock_select && lock_reg);     // [RULE_11]
	assign lock_fall    = lock_reg && !lock_next;

	//------------------------------------------------------------------
	// event flags
	//------------------------------------------------------------------
	assign evt_set[EVT_LOL_BIT]       = lock_fall;                    // [RULE_06]
	assign evt_set[EVT_RAIL_LOW_BIT]  = i_det.rail_low;               // [RULE_05]
	assign evt_set[EVT_RAIL_HIGH_BIT] = i_det.rail_high;              // [RULE_04]
	assign evt_clr  = wr_evt ? i_reg_req.wdata[EVT_W-1:0] : '0;       // [RULE_07]
	assign evt_next = (evt_reg & ~evt_clr) | evt_set;                 // [RULE_12]

	//------------------------------------------------------------------
	// loss-of-lock counter
	//------------------------------------------------------------------
	// a loss in the write cycle counts on top of the written value
	assign cnt_base = wr_cnt ? i_reg_req.wdata[CNT_W-1:0] : cnt_reg;  // [RULE_09]
	assign cnt_next = lock_fall ? sat_inc(cnt_base) : cnt_base;       // [RULE_08]

	//------------------------------------------------------------------
	// read mux
	//------------------------------------------------------------------
	assign sts_word = {5'h00, i_det.rail_high, i_det.rail_low,       // [RULE_02]
	                   lock_reg};                                     // [RULE_01]

	always_comb begin
		unique case (i_reg_req.addr)
			PLL_LOCK_STATUS_IDX:       rdata_next = sts_word;         // [RULE_03]
			PLL_EVENT_FLAGS_IDX:       rdata_next = {5'h00, evt_reg};
			PLL_LOCK_LOSS_COUNTER_IDX: rdata_next = {4'h0, cnt_reg};  // [RULE_13]
			default:                   rdata_next = REG_RESET_VAL;
		endcase
	end

	//------------------------------------------------------------------
	// registers
	//------------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			deb_cnt_reg <= DEB_ZERO;
			deb_reg     <= 1'b0;
			lock_reg    <= 1'b0;
			evt_reg     <= '0;                                        // [RULE_13]
			cnt_reg     <= CNT_ZERO;
			o_reg_rdata <= REG_RESET_VAL;
		end else if (i_clk_en) begin
			deb_cnt_reg <= deb_cnt_next;
			deb_reg     <= deb_next;
			lock_reg    <= lock_next;
			evt_reg     <= evt_next;
			cnt_reg     <= cnt_next;
			o_reg_rdata <= rdata_next;
		end
	end

	assign o_lock = lock_reg;

	//------------------------------------------------------------------
	// checks
	//------------------------------------------------------------------
	chk_status_lock_bit: assert property (                           // [RULE_01]
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_clk_en && i_reg_req.addr == PLL_LOCK_STATUS_IDX)
		|=> o_reg_rdata[STS_LOCK_BIT] == $past(lock_reg))
		else $error("status lock bit does not follow lock");

	chk_status_rail_high: assert property (                          // [RULE_02]
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_clk_en && i_reg_req.addr == PLL_LOCK_STATUS_IDX)
		|=> o_reg_rdata[STS_RAIL_HIGH_BIT] == $past(i_det.rail_high))
		else $error("status rail high bit wrong");

	chk_status_rail_low: assert property (                           // [RULE_03]
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_clk_en && i_reg_req.addr == PLL_LOCK_STATUS_IDX)
		|=> o_reg_rdata[STS_RAIL_LOW_BIT] == $past(i_det.rail_low)
		&& o_reg_rdata[7:3] == 5'h00)
		else $error("status rail low bit or reserved bits wrong");

	chk_rail_high_event: assert property (                           // [RULE_04]
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_clk_en && i_det.rail_high) |=> evt_reg[EVT_RAIL_HIGH_BIT])
		else $error("rail high event not set");

	chk_rail_low_event: assert property (                            // [RULE_05]
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_clk_en && i_det.rail_low) |=> evt_reg[EVT_RAIL_LOW_BIT])
		else $error("rail low event not set");

	chk_lol_event_set: assert property (                             // [RULE_06]
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_clk_en && lock_reg && !lock_next) ##1 i_clk_en
		|=> o_reg_rdata[EVT_LOL_BIT] ||
		    $past(i_reg_req.addr) != PLL_EVENT_FLAGS_IDX)
		else $error("loss of lock event not reported");

	chk_flag_clear_w1c: assert property (                            // [RULE_07]
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_clk_en && $fell(evt_reg[EVT_LOL_BIT]) == 1'b0 &&
		 evt_reg[EVT_LOL_BIT] && !lock_fall &&
		 !(wr_evt && i_reg_req.wdata[EVT_LOL_BIT]))
		|=> evt_reg[EVT_LOL_BIT])
		else $error("loss of lock flag cleared without write of 1");

	chk_set_beats_clear: assert property (                           // [RULE_12]
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_clk_en && wr_evt && i_reg_req.wdata[EVT_RAIL_LOW_BIT] &&
		 i_det.rail_low) |=> evt_reg[EVT_RAIL_LOW_BIT])
		else $error("clear won over a simultaneous set");

	chk_counter_saturate: assert property (                          // [RULE_08]
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_clk_en && !wr_cnt && lock_fall)
		|=> cnt_reg == (($past(cnt_reg) == CNT_MAX) ? CNT_MAX :
		                4'($past(cnt_reg) + CNT_ONE)))
		else $error("loss of lock counter step wrong");

	chk_counter_load: assert property (                              // [RULE_09]
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_clk_en && wr_cnt && !lock_fall)
		|=> cnt_reg == $past(i_reg_req.wdata[CNT_W-1:0]))
		else $error("counter write did not load");

	chk_debounce_none: assert property (                             // [RULE_10]
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_clk_en && i_lock_timer_sel == DEB_SEL_NONE &&
		 !i_sticky_lock_select) |=> lock_reg == $past(i_det.raw_lock))
		else $error("zero debounce did not pass lock through");

	chk_debounce_wait: assert property (                             // [RULE_10]
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_clk_en && i_lock_timer_sel == DEB_SEL_SHORT && differs &&
		 deb_cnt_reg < 16'(DEB_SHORT_CYC - 1)) |=> deb_reg == $past(deb_reg))
		else $error("lock taken before debounce interval");

	chk_sticky_lock_hold: assert property (                          // [RULE_11]
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_clk_en && i_sticky_lock_select && lock_reg) |=> lock_reg)
		else $error("sticky lock dropped");

	chk_lock_follows_deb: assert property (                          // [RULE_11]
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_clk_en && !i_sticky_lock_select) |=> lock_reg == deb_reg)
		else $error("real-time lock does not follow debounced lock");

	chk_debounce_mid: assert property (                              // [RULE_10]
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_clk_en && i_lock_timer_sel == DEB_SEL_MID && differs &&
		 deb_cnt_reg < 16'(DEB_MID_CYCLES - 1))
		|=> deb_reg == $past(deb_reg))
		else $error("lock taken before mid debounce interval");

	chk_debounce_take: assert property (                             // [RULE_10]
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_clk_en && i_lock_timer_sel == DEB_SEL_LONG && differs &&
		 deb_cnt_reg == 16'(DEB_LONG_CYCLES - 1))
		|=> deb_reg == $past(i_det.raw_lock))
		else $error("lock not taken at end of long debounce interval");

	chk_lol_event_fall: assert property (                            // [RULE_06]
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_clk_en && lock_fall) |=> evt_reg[EVT_LOL_BIT])
		else $error("loss of lock flag not set on lock fall");

	chk_flags_no_drop: assert property (                             // [RULE_07]
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_clk_en && !wr_evt) |=> ($past(evt_reg) & ~evt_reg) == '0)
		else $error("event flag dropped without a write");

	chk_zero_write_keeps: assert property (                          // [RULE_12]
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_clk_en && wr_evt)
		|=> ($past(evt_reg) & ~$past(i_reg_req.wdata[EVT_W-1:0]) &
		     ~evt_reg) == '0)
		else $error("event flag cleared by a write of 0");

	chk_counter_hold: assert property (                              // [RULE_08]
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_clk_en && !wr_cnt && !lock_fall) |=> cnt_reg == $past(cnt_reg))
		else $error("loss of lock counter moved without cause");

	chk_event_readback: assert property (                            // [RULE_13]
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_clk_en && i_reg_req.addr == PLL_EVENT_FLAGS_IDX)
		|=> o_reg_rdata == {5'h00, $past(evt_reg)})
		else $error("event read data or reserved bits wrong");

	chk_counter_readback: assert property (                          // [RULE_13]
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_clk_en && i_reg_req.addr == PLL_LOCK_LOSS_COUNTER_IDX)
		|=> o_reg_rdata == {4'h0, $past(cnt_reg)})
		else $error("counter read data or reserved bits wrong");

	chk_unmapped_zero: assert property (                             // [RULE_13]
		@(posedge i_core_clk) disable iff (i_sys_rst)
		(i_clk_en && i_reg_req.addr != PLL_LOCK_STATUS_IDX &&
		 i_reg_req.addr != PLL_EVENT_FLAGS_IDX &&
		 i_reg_req.addr != PLL_LOCK_LOSS_COUNTER_IDX)
		|=> o_reg_rdata == REG_RESET_VAL)
		else $error("unmapped read not zero");

	chk_reset_clears: assert property (                              // [RULE_13]
		@(posedge i_core_clk)
		i_sys_rst |=> (evt_reg == '0 && cnt_reg == CNT_ZERO &&
		               !lock_reg && o_reg_rdata == REG_RESET_VAL))
		else $error("registers not zero after reset");

endmodule

// ---- sim/tb_top.sv ----
//----------------------------------------------------------------------
// Purpose : self-checking bench for the pll lock event monitor
// Assumes : register port driven 1 ns after each rising edge
// Notes   : mid and long debounce shortened to 20 and 40 cycles
//----------------------------------------------------------------------
`timescale 1ns/100ps

module tb_top;
	import pllm_pkg::*;

	//------------------------------------------------------------------
	// signals
	//------------------------------------------------------------------
	localparam int  MID_N  = 20;
	localparam int  LONG_N = 40;
	logic           i_core_clk;
	logic           i_sys_rst;
	logic           i_clk_en;
	pllm_det_t      i_det;
	logic [1:0]     i_lock_timer_sel;
	logic           i_sticky_lock_select;
	pllm_reg_req_t  i_reg_req;
	logic [7:0]     o_reg_rdata;
	logic           o_lock;
	int             n_mismatch;
	int             checks;
	int             deb_n [3];

	pllm_monitor #(
		.DEB_MID_CYCLES  (MID_N),
		.DEB_LONG_CYCLES (LONG_N)
	) DUT (
		.i_core_clk           (i_core_clk),
		.i_sys_rst            (i_sys_rst),
		.i_clk_en             (i_clk_en),
		.i_det                (i_det),
		.i_lock_timer_sel     (i_lock_timer_sel),
		.i_sticky_lock_select (i_sticky_lock_select),
		.i_reg_req            (i_reg_req),
		.o_reg_rdata          (o_reg_rdata),
		.o_lock               (o_lock)
	);

	//------------------------------------------------------------------
	// tasks
	//------------------------------------------------------------------
	task automatic step(input int n);
		repeat (n) @(posedge i_core_clk);
		#1;
	endtask

	task automatic chk(input string what, input logic [7:0] exp,
			input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic lock_chk(input logic exp);
		chk("o_lock", {7'h00, exp}, {7'h00, o_lock});
	endtask

	// write strobe drops before returning, one idle cycle follows
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		i_reg_req = '{addr: a, wr: 1'b1, wdata: d};
		step(1);
		i_reg_req.wr = 1'b0;
		step(1);
	endtask

	task automatic rd(input logic [1:0] a, input logic [7:0] exp);
		i_reg_req.addr = a;
		step(1);
		chk($sformatf("reg %0d", a), exp, o_reg_rdata);
	endtask

	task automatic lose();
		i_det.raw_lock = 1'b1;
		step(3);
		i_det.raw_lock = 1'b0;
		step(3);
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	//------------------------------------------------------------------
	// clock, watchdog
	//------------------------------------------------------------------
	initial begin
		i_core_clk = 1'b0;
		forever #20 i_core_clk = ~i_core_clk;
	end

	initial begin
		#400000;
		n_mismatch++;
		results();
	end

	//------------------------------------------------------------------
	// tests
	//------------------------------------------------------------------
	initial begin
		n_mismatch = 0;
		checks = 0;
		deb_n = '{DEB_SHORT_CYC, MID_N, LONG_N};
		i_sys_rst = 1'b1;
		i_clk_en = 1'b1;
		i_det = '0;
		i_lock_timer_sel = DEB_SEL_NONE;
		i_sticky_lock_select = 1'b0;
		i_reg_req = '0;
		step(2);
		i_sys_rst = 1'b0;
		for (int a = 0; a < 4; a++) rd(a[1:0], 8'h00);
		$display("test reset done");

		i_det.raw_lock = 1'b1;
		step(3);
		lock_chk(1'b1);
		rd(PLL_LOCK_STATUS_IDX, 8'h01);
		rd(PLL_EVENT_FLAGS_IDX, 8'h00);
		i_det.raw_lock = 1'b0;
		step(3);
		rd(PLL_LOCK_STATUS_IDX, 8'h00);
		rd(PLL_EVENT_FLAGS_IDX, 8'h01);
		rd(PLL_LOCK_LOSS_COUNTER_IDX, 8'h01);
		wr(PLL_EVENT_FLAGS_IDX, 8'h00);
		rd(PLL_EVENT_FLAGS_IDX, 8'h01);
		wr(PLL_EVENT_FLAGS_IDX, 8'h01);
		rd(PLL_EVENT_FLAGS_IDX, 8'h00);
		$display("test lock loss done");

		i_det.rail_high = 1'b1;
		step(2);
		rd(PLL_LOCK_STATUS_IDX, 8'h04);
		rd(PLL_EVENT_FLAGS_IDX, 8'h04);
		wr(PLL_EVENT_FLAGS_IDX, 8'h04);
		rd(PLL_EVENT_FLAGS_IDX, 8'h04);
		i_det.rail_high = 1'b0;
		i_det.rail_low = 1'b1;
		step(2);
		rd(PLL_LOCK_STATUS_IDX, 8'h02);
		wr(PLL_EVENT_FLAGS_IDX, 8'h02);
		i_det.rail_low = 1'b0;
		step(2);
		rd(PLL_EVENT_FLAGS_IDX, 8'h06);
		wr(PLL_EVENT_FLAGS_IDX, 8'hff);
		rd(PLL_EVENT_FLAGS_IDX, 8'h00);
		wr(PLL_LOCK_STATUS_IDX, 8'hff);
		rd(PLL_LOCK_STATUS_IDX, 8'h00);
		wr(2'h3, 8'hff);
		rd(2'h3, 8'h00);
		$display("test rails done");

		wr(PLL_LOCK_LOSS_COUNTER_IDX, 8'hfe);
		rd(PLL_LOCK_LOSS_COUNTER_IDX, 8'h0e);
		lose();
		lose();
		rd(PLL_LOCK_LOSS_COUNTER_IDX, 8'h0f);
		lose();
		rd(PLL_LOCK_LOSS_COUNTER_IDX, 8'h0f);
		wr(PLL_LOCK_LOSS_COUNTER_IDX, 8'h00);
		rd(PLL_LOCK_LOSS_COUNTER_IDX, 8'h00);
		wr(PLL_EVENT_FLAGS_IDX, 8'h01);
		$display("test counter done");

		i_sticky_lock_select = 1'b1;
		lose();
		lock_chk(1'b1);
		rd(PLL_EVENT_FLAGS_IDX, 8'h00);
		i_sticky_lock_select = 1'b0;
		step(3);
		lock_chk(1'b0);
		$display("test sticky done");

		for (int k = 0; k < 3; k++) begin
			i_lock_timer_sel = 2'(k + 1);
			i_det.raw_lock = 1'b1;
			step(deb_n[k] - 1);
			lock_chk(1'b0);
			step(4);
			lock_chk(1'b1);
			i_det.raw_lock = 1'b0;
			step(deb_n[k] + 4);
		end
		$display("test debounce done");

		i_lock_timer_sel = DEB_SEL_NONE;
		i_clk_en = 1'b0;
		i_det.raw_lock = 1'b1;
		step(5);
		lock_chk(1'b0);
		i_clk_en = 1'b1;
		step(3);
		lock_chk(1'b1);
		$display("test enable done");
		results();
	end

endmodule
